// ==== logic/cms_counter_mode_sequencer.sv ====
// Operation
// RQ1: ungated strobe counts only after arm
// RQ2: ungated strobe reloads load, disarms on tc
// RQ3: disarmed counter ignores source edges except at tc
// RQ4: level gated strobe counts only gate active
// RQ5: level gated strobe needs arm to count
// RQ6: level gated strobe reloads, disarms on tc
// RQ7: mode from four select fields, 000 ungated
// RQ8: reload source clear reloads from load
// RQ9: reload source set alternates hold, load
// RQ10: no repetition disarms after one/two tc
// RQ11: repetition set never self disarms
// RQ12: level gating counts only while gate active
// RQ13: gate edge starts, tc stops count
// RQ14: no retrigger with special gate clear
// RQ15: special gate edge captures, then reloads load
// RQ16: special alternate picks hold when gate high
// RQ17: software never programs reserved mode codes
// RQ18: only rising source and gate edges act
// RQ19: tc state counts next source edge unless mode is reserved
// RQ20: reset leaves counter disarmed
`default_nettype none
module cms_counter_mode_sequencer
	import cms_pkg::*;
(
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_srst,
	// external pins
	input  wire logic              i_source,
	input  wire logic              i_gate,
	// host commands, one-cycle pulses
	input  wire logic              i_arm,
	input  wire logic              i_disarm,
	input  wire logic              i_load_cmd,
	input  wire logic              i_hold_write,
	// host data
	input  wire logic [CNT_W-1:0]  i_load_value,
	input  wire logic [CNT_W-1:0]  i_hold_value,
	// mode select
	input  wire logic              i_special_gate_bit,
	input  wire logic              i_reload_source_bit,
	input  wire logic              i_repetition_bit,
	input  wire logic [2:0]        i_gate_control_field,
	// status
	output logic      [CNT_W-1:0]  o_count,
	output logic      [CNT_W-1:0]  o_hold,
	output logic                   o_armed,
	output logic                   o_triggered,
	output logic                   o_terminal_count_event,
	output logic                   o_reserved_mode
);
	logic [PIN_N-1:0] pin_level;
	logic [PIN_N-1:0] pin_rise;

	cms_pin_sync u_sync
	(
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_pin   ({i_gate, i_source}),
		.o_level (pin_level),
		.o_rise  (pin_rise)
	);

	logic             src_edge;
	logic             gate_lvl;
	logic             gate_edge;
	assign src_edge  = pin_rise[PIN_SRC]; // RQ18
	assign gate_edge = pin_rise[PIN_GATE]; // RQ18
	assign gate_lvl  = pin_level[PIN_GATE];

	// state
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] hold;
	logic             armed;
	logic             triggered;
	logic             phase;
	logic             tc_event;
	logic [CNT_W-1:0] next_count;
	logic [CNT_W-1:0] next_hold;
	logic             next_armed;
	logic             next_triggered;
	logic             next_phase;
	logic             next_tc_event;

	// decode
	logic             gc_none;
	logic             gc_edge;
	logic             gc_level;
	logic             reserved;
	logic             at_tc;
	logic             enable;
	logic             count_now;
	logic             leave_tc;
	logic             capture;
	logic             last_tc;

	always_comb
	begin
		gc_none  = (i_gate_control_field == CMS_GC_NONE); // RQ7
		gc_edge  = (i_gate_control_field == CMS_GC_EDGE);
		gc_level = !gc_none && !gc_edge;
		// codes without behaviour just freeze the counter
		reserved = i_special_gate_bit &&
			((!i_reload_source_bit && gc_none) || (i_reload_source_bit && !gc_none)); // RQ17
		at_tc    = (count == CNT_TC);
		if (gc_none)
			enable = armed; // RQ1
		else if (gc_level)
			enable = armed && gate_lvl; // RQ4 RQ5 RQ12
		else
			enable = armed && triggered; // RQ13
		count_now = src_edge && !reserved && (at_tc || enable); // RQ3 RQ19
		leave_tc  = count_now && at_tc;
		capture   = i_special_gate_bit && !i_reload_source_bit && !gc_none
			&& armed && gate_edge; // RQ15
		// second tc of an alternating pair, or any tc otherwise
		last_tc   = !i_reload_source_bit || phase; // RQ10
	end

	always_comb
	begin
		next_count     = count;
		next_hold      = hold;
		next_armed     = armed;
		next_triggered = triggered;
		next_phase     = phase;
		next_tc_event  = 1'b0;
		if (i_hold_write)
			next_hold = i_hold_value;
		if (i_load_cmd)
			next_count = i_load_value;
		else if (capture)
		begin
			next_hold  = count; // RQ15
			next_count = i_load_value; // RQ15
		end
		else if (leave_tc)
		begin
			if (i_reload_source_bit && i_special_gate_bit)
				next_count = gate_lvl ? hold : i_load_value; // RQ16
			else if (i_reload_source_bit)
				next_count = phase ? i_load_value : hold; // RQ9
			else
				next_count = i_load_value; // RQ8
			if (i_reload_source_bit)
				next_phase = !phase;
			if (!i_repetition_bit && last_tc)
				next_armed = 1'b0; // RQ2 RQ6 RQ10 RQ11
			if (gc_edge && last_tc)
				next_triggered = 1'b0; // RQ13
		end
		else if (count_now)
		begin
			next_count    = count - CNT_STEP;
			next_tc_event = (count == CNT_PRE_TC);
		end
		// edge start only from idle when special gate is clear
		if (gc_edge && armed && gate_edge && (i_special_gate_bit || !triggered))
			next_triggered = 1'b1; // RQ13 RQ14
		if (i_arm)
		begin
			next_armed     = 1'b1;
			next_phase     = 1'b0;
			next_triggered = 1'b0;
		end
		if (i_disarm)
			next_armed = 1'b0;
		if (i_srst)
		begin
			next_count     = CNT_RESET;
			next_hold      = CNT_RESET;
			next_armed     = 1'b0; // RQ20
			next_triggered = 1'b0;
			next_phase     = 1'b0;
			next_tc_event  = 1'b0;
		end
	end

	always_ff @(posedge i_clk)
	begin
		count     <= next_count;
		hold      <= next_hold;
		armed     <= next_armed;
		triggered <= next_triggered;
		phase     <= next_phase;
		tc_event  <= next_tc_event;
	end

	assign o_count                = count;
	assign o_hold                 = hold;
	assign o_armed                = armed;
	assign o_triggered            = triggered;
	assign o_terminal_count_event = tc_event;
	assign o_reserved_mode        = reserved;

	// checks
	property p_disarmed_idle;
		@(posedge i_clk) disable iff (i_srst)
		(!armed && !at_tc && !i_load_cmd) |=> (count == $past(count));
	endproperty
	a_disarmed_idle: assert property (p_disarmed_idle) // RQ3
		else $error("disarmed counter changed");

	property p_load_reload_disarm;
		@(posedge i_clk) disable iff (i_srst)
		(leave_tc && !i_special_gate_bit && !i_reload_source_bit && !i_repetition_bit
			&& !i_load_cmd && !i_arm)
		|=> (count == $past(i_load_value)) && !armed;
	endproperty
	a_load_reload_disarm: assert property (p_load_reload_disarm) // RQ2
		else $error("tc did not reload from load and disarm");

	property p_tc_counts;
		@(posedge i_clk) disable iff (i_srst)
		(at_tc && src_edge && !reserved && !armed && !i_load_cmd && !capture)
		|=> (count != $past(count)) || (count == $past(i_load_value));
	endproperty
	a_tc_counts: assert property (p_tc_counts) // RQ19
		else $error("tc state ignored a source edge");

	property p_level_blocks;
		@(posedge i_clk) disable iff (i_srst)
		(armed && gc_level && !gate_lvl && !at_tc && !i_load_cmd && !capture)
		|=> $stable(count);
	endproperty
	a_level_blocks: assert property (p_level_blocks) // RQ4
		else $error("counted with gate inactive");

	property p_repeat_keeps_arm;
		@(posedge i_clk) disable iff (i_srst)
		(leave_tc && armed && i_repetition_bit && !i_disarm) |=> armed;
	endproperty
	a_repeat_keeps_arm: assert property (p_repeat_keeps_arm) // RQ11
		else $error("repeating mode disarmed itself");

	property p_alt_first_hold;
		@(posedge i_clk) disable iff (i_srst)
		(leave_tc && !i_special_gate_bit && i_reload_source_bit && !phase && !i_load_cmd)
		|=> (count == $past(hold));
	endproperty
	a_alt_first_hold: assert property (p_alt_first_hold) // RQ9
		else $error("first alternating tc not from hold");

	property p_twice_then_disarm;
		@(posedge i_clk) disable iff (i_srst)
		(leave_tc && armed && i_reload_source_bit && !i_repetition_bit && !phase
			&& !i_disarm)
		|=> armed;
	endproperty
	a_twice_then_disarm: assert property (p_twice_then_disarm) // RQ10
		else $error("disarmed on first of two tc");

	property p_capture;
		@(posedge i_clk) disable iff (i_srst)
		(capture && !i_load_cmd && !i_hold_write)
		|=> (hold == $past(count)) && (count == $past(i_load_value));
	endproperty
	a_capture: assert property (p_capture) // RQ15
		else $error("gate edge capture wrong");

	property p_gate_select;
		@(posedge i_clk) disable iff (i_srst)
		(leave_tc && i_special_gate_bit && i_reload_source_bit && gc_none && gate_lvl
			&& !i_load_cmd)
		|=> (count == $past(hold));
	endproperty
	a_gate_select: assert property (p_gate_select) // RQ16
		else $error("high gate tc not from hold");

	property p_gate_low_load;
		@(posedge i_clk) disable iff (i_srst)
		(leave_tc && i_special_gate_bit && i_reload_source_bit && gc_none && !gate_lvl
			&& !i_load_cmd)
		|=> (count == $past(i_load_value));
	endproperty
	a_gate_low_load: assert property (p_gate_low_load) // RQ16
		else $error("low gate tc not from load");

	property p_no_retrigger;
		@(posedge i_clk) disable iff (i_srst)
		(!i_special_gate_bit && !i_load_cmd && !leave_tc)
		|=> (count == $past(count)) || (count == ($past(count) - CNT_STEP));
	endproperty
	a_no_retrigger: assert property (p_no_retrigger) // RQ14
		else $error("gate reloaded counter without tc");

	property p_edge_waits;
		@(posedge i_clk) disable iff (i_srst)
		(armed && gc_edge && !triggered && !at_tc && !i_load_cmd && !capture)
		|=> $stable(count);
	endproperty
	a_edge_waits: assert property (p_edge_waits) // RQ13
		else $error("edge mode counted before trigger");

	property p_reset_disarms;
		@(posedge i_clk) i_srst |=> !armed && !triggered;
	endproperty
	a_reset_disarms: assert property (p_reset_disarms) // RQ20
		else $error("armed after reset");

	c_strobe_tc: cover property (@(posedge i_clk) disable iff (i_srst)
		leave_tc && !i_repetition_bit && gc_none);
	c_alt_pair: cover property (@(posedge i_clk) disable iff (i_srst)
		leave_tc && phase && i_reload_source_bit);
	c_capture: cover property (@(posedge i_clk) disable iff (i_srst) capture);
	c_edge_run: cover property (@(posedge i_clk) disable iff (i_srst)
		triggered && count_now);
endmodule
`default_nettype wire

// ==== logic/cms_pkg.sv ====
`default_nettype none
package cms_pkg;
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_RESET   = 16'h0000;
	localparam logic [15:0] CNT_TC      = 16'h0001;
	localparam logic [15:0] CNT_PRE_TC  = 16'h0002;
	localparam logic [15:0] CNT_STEP    = 16'h0001;
	// gate control field encodings; other non-zero codes act as level gating
	typedef enum logic [2:0]
	{
		CMS_GC_NONE  = 3'h0,
		CMS_GC_LEVEL = 3'h1,
		CMS_GC_EDGE  = 3'h2
	} cms_gate_t;
	// index of each pin in the synchroniser vector
	localparam int PIN_SRC  = 0;
	localparam int PIN_GATE = 1;
	localparam int PIN_N    = 2;
endpackage
`default_nettype wire

// ==== logic/cms_pin_sync.sv ====
`default_nettype none
module cms_pin_sync
	import cms_pkg::*;
(
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_srst,
	// raw pins
	input  wire logic [PIN_N-1:0]  i_pin,
	// synchronised level and rising edge
	output logic      [PIN_N-1:0]  o_level,
	output logic      [PIN_N-1:0]  o_rise
);
	logic [PIN_N-1:0] meta;
	logic [PIN_N-1:0] sync;
	logic [PIN_N-1:0] last;
	logic [PIN_N-1:0] next_meta;
	logic [PIN_N-1:0] next_sync;
	logic [PIN_N-1:0] next_last;

	always_comb
	begin
		next_meta = i_pin;
		next_sync = meta;
		next_last = sync;
		if (i_srst)
		begin
			next_meta = '0;
			next_sync = '0;
			next_last = '0;
		end
	end

	always_ff @(posedge i_clk)
	begin
		meta <= next_meta;
		sync <= next_sync;
		last <= next_last;
	end

	// edge taken from second and third stage only, never the first
	assign o_level = sync;
	assign o_rise  = sync & ~last;
endmodule
`default_nettype wire

// ==== verif/cms_pin_model.sv ====
`default_nettype none
module cms_pin_model
(
	// clock
	input  wire logic i_clk,
	// bench requests
	input  wire logic i_fire,
	input  wire logic i_gate_lvl,
	// pins toward the block
	output logic      o_source,
	output logic      o_gate
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] left   = 2'h0;
	logic       gate_q = 1'b0;
	// three clocks high keeps the pulse above the two-clock minimum
	always_ff @(posedge i_clk)
	begin
		if (i_fire)
			left <= 2'h3;
		else if (left != 2'h0)
			left <= left - 2'h1;
		gate_q <= i_gate_lvl;
	end
	assign o_source = (left != 2'h0);
	assign o_gate   = gate_q;
endmodule
`default_nettype wire

// ==== verif/test_counter_mode_sequencer.sv ====
`default_nettype none
module test_counter_mode_sequencer
	import cms_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic             i_clk = 1'b0, i_srst = 1'b1, fire = 1'b0, gate_lvl = 1'b0;
	logic             i_arm = 1'b0, i_disarm = 1'b0, i_load_cmd = 1'b0, i_hold_write = 1'b0;
	logic             sg = 1'b0, rs = 1'b0, rp = 1'b0, mon_on = 1'b0;
	logic [2:0]       gc = 3'h0;
	logic [CNT_W-1:0] ld = 16'h0002, hv = 16'h0003, exp_cnt = 16'h0000, prev_cnt;
	logic [CNT_W-1:0] q[$];
	logic             src, gate, armed, trig, tc_ev, rsv;
	logic [CNT_W-1:0] cnt, hold;
	int               err_total = 0, cmp_count = 0, cyc = 0, tc_seen = 0, exp_tc = 0;
	int unsigned      seed_v;

	cms_pin_model i_pins (.i_clk(i_clk), .i_fire(fire), .i_gate_lvl(gate_lvl),
		.o_source(src), .o_gate(gate));
	cms_counter_mode_sequencer i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_source(src),
		.i_gate(gate), .i_arm(i_arm), .i_disarm(i_disarm), .i_load_cmd(i_load_cmd),
		.i_hold_write(i_hold_write), .i_load_value(ld), .i_hold_value(hv),
		.i_special_gate_bit(sg), .i_reload_source_bit(rs), .i_repetition_bit(rp),
		.i_gate_control_field(gc), .o_count(cnt), .o_hold(hold), .o_armed(armed),
		.o_triggered(trig), .o_terminal_count_event(tc_ev), .o_reserved_mode(rsv));

	initial
	begin
		forever #50 i_clk = ~i_clk;
	end

	task automatic finish_test();
		$display("compares %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [CNT_W-1:0] e, input logic [CNT_W-1:0] g);
		cmp_count++;
		if (g !== e)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	task automatic go(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask

	// only changes are queued, the watcher cannot see a same-value reload
	task automatic expect_cnt(input logic [CNT_W-1:0] v);
		if (v !== exp_cnt)
			q.push_back(v);
		exp_cnt = v;
		if (v == CNT_TC)
			exp_tc++;
	endtask

	task automatic pulse(input logic counts, input logic [CNT_W-1:0] v);
		if (counts)
			expect_cnt(v);
		go(fire);
		tick(6);
	endtask

	task automatic run(input logic [CNT_W-1:0] start, input logic [CNT_W-1:0] r);
		for (int k = 1; k < start; k++)
			pulse(1'b1, start - 16'(k));
		pulse(1'b1, r);
	endtask

	task automatic mode(input logic a, input logic b, input logic c, input logic [2:0] g);
		sg = a;
		rs = b;
		rp = c;
		gc = g;
		tick(1);
	endtask

	always @(negedge i_clk)
	begin
		if (mon_on && tc_ev === 1'b1)
			tc_seen++;
		if (mon_on && cnt !== prev_cnt)
		begin
			chk("count", (q.size() == 0) ? 16'hffff : q.pop_front(), cnt);
			prev_cnt = cnt;
		end
	end

	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_total++;
			finish_test();
		end
	end

	initial
	begin
		seed_v = $urandom(32'h4587);
		ld = 16'($urandom_range(5, 2));
		hv = 16'($urandom_range(5, 2));
		tick(5);
		i_srst = 1'b0;
		prev_cnt = cnt;
		mon_on = 1'b1;
		chk("armed", 16'h0000, {15'h0000, armed});
		chk("reserved", 16'h0000, {15'h0000, rsv});
		go(i_load_cmd);
		expect_cnt(ld);
		pulse(1'b0, 16'h0000);
		go(i_arm);
		chk("armed", 16'h0001, {15'h0000, armed});
		run(ld, ld);
		chk("armed", 16'h0000, {15'h0000, armed});
		pulse(1'b0, 16'h0000);
		mode(1'b0, 1'b0, 1'b0, 3'h1);
		go(i_arm);
		pulse(1'b0, 16'h0000);
		gate_lvl = 1'b1;
		tick(4);
		run(ld, ld);
		chk("armed", 16'h0000, {15'h0000, armed});
		pulse(1'b0, 16'h0000);
		mode(1'b0, 1'b0, 1'b1, 3'h0);
		go(i_arm);
		run(ld, ld);
		run(ld, ld);
		chk("armed", 16'h0001, {15'h0000, armed});
		for (int k = 1; k < ld; k++)
			pulse(1'b1, ld - 16'(k));
		go(i_disarm);
		chk("armed", 16'h0000, {15'h0000, armed});
		pulse(1'b1, ld);
		pulse(1'b0, 16'h0000);
		go(i_hold_write);
		mode(1'b0, 1'b1, 1'b0, 3'h0);
		go(i_arm);
		run(ld, hv);
		run(hv, ld);
		chk("armed", 16'h0000, {15'h0000, armed});
		gate_lvl = 1'b0;
		mode(1'b0, 1'b0, 1'b0, 3'h2);
		go(i_arm);
		tick(4);
		pulse(1'b0, 16'h0000);
		gate_lvl = 1'b1;
		tick(6);
		chk("triggered", 16'h0001, {15'h0000, trig});
		run(ld, ld);
		chk("triggered", 16'h0000, {15'h0000, trig});
		gate_lvl = 1'b0;
		mode(1'b1, 1'b0, 1'b0, 3'h1);
		go(i_arm);
		gate_lvl = 1'b1;
		tick(6);
		chk("hold", ld, hold);
		pulse(1'b1, ld - 16'h0001);
		gate_lvl = 1'b0;
		tick(6);
		expect_cnt(ld);
		gate_lvl = 1'b1;
		tick(6);
		chk("hold", ld - 16'h0001, hold);
		go(i_hold_write);
		mode(1'b1, 1'b1, 1'b1, 3'h0);
		go(i_arm);
		run(ld, hv);
		gate_lvl = 1'b0;
		tick(4);
		run(hv, ld);
		chk("armed", 16'h0001, {15'h0000, armed});
		mode(1'b1, 1'b0, 1'b0, 3'h0);
		chk("reserved", 16'h0001, {15'h0000, rsv});
		chk("tc events", 16'(exp_tc), 16'(tc_seen));
		chk("pending", 16'h0000, 16'(q.size()));
		finish_test();
	end
endmodule
`default_nettype wire
